//--- src/adcs_pkg.sv
package adcs_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL0   = 8'h00;
    localparam logic [7:0] ADDR_PINREF  = 8'h04;
    localparam logic [7:0] ADDR_TIMING  = 8'h08;
    localparam logic [7:0] ADDR_RESH    = 8'h0c;
    localparam logic [7:0] ADDR_RESL    = 8'h10;
    localparam logic [7:0] ADDR_IRQ     = 8'h14;
    // field positions
    localparam int CTRL0_ENABLE   = 0;
    localparam int CTRL0_GO       = 1;
    localparam int CTRL0_CHAN_LSB = 2;
    localparam int PINREF_CFG_LSB = 0;
    localparam int PINREF_VPOS    = 4;
    localparam int PINREF_VNEG    = 5;
    localparam int TIMING_CLK_LSB = 0;
    localparam int TIMING_ACQ_LSB = 3;
    localparam int TIMING_ALIGN   = 7;
    localparam int IRQ_FLAG       = 0;
    localparam int IRQ_ENABLE     = 1;
    // reset values
    localparam logic [7:0] CTRL0_RESET  = 8'h00;
    localparam logic [7:0] PINREF_RESET = 8'h00;
    localparam logic [7:0] TIMING_RESET = 8'h00;
    // timing
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         INSTR_CYCLE_NS = 40;
    localparam logic [2:0] HOLDOFF_CYCLES =
        3'((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] CONV_TADS      = 5'h0b;
    localparam logic [4:0] RECOVER_TADS   = 5'h02;
    localparam logic [9:0] TRIAL_START    = 10'h200;
    localparam logic [2:0] ACQ_NONE       = 3'h0;
    localparam logic [1:0] CLK_RC_CODE    = 2'h3;

    typedef enum logic [2:0] {
        st_idle,
        st_holdoff,
        st_acq,
        st_conv,
        st_recover
    } adcs_state_t;

    typedef struct packed {
        logic       power;
        logic       sample;
        logic       hold;
        logic       vref_pos_ext;
        logic       vref_neg_ext;
        logic [3:0] channel;
        logic [3:0] port_config;
        logic [9:0] trial;
    } adcs_analog_t;
endpackage

//--- src/adcs_sequencer.sv
`timescale 1ns/1ps
// Function
// - format bit picks right or left alignment
// - acquisition field maps to 0..20 periods
// - clock field picks divider or RC
// - RC clock held off one instruction cycle
// - references selectable: rails or external pins
// - sleep conversions only with RC clock
// - reset clears controls, aborts conversion
// - completion stores result, clears go, flags
// - result pair has no reset value
// - two periods wait before next acquisition
// - zero acquisition converts immediately on go, after the holdoff with RC clock
// - nonzero acquisition samples then converts automatically
// - sampling resumes after each conversion
// - go stays set through acquisition and conversion
// - hold capacitor isolated while converting
// - result has 1024 codes, ten bits
// - conversion takes eleven clock periods
// - clearing go aborts, result kept
// - enable powers module; go shows busy
module adcs_sequencer
    import adcs_pkg::*;
#(
    parameter int RESULT_W = 10
)
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          rc_tick,
    input  wire logic          device_sleep,
    input  wire logic          cmp_above,
    output adcs_analog_t       analog,
    output logic               conv_irq
);

    adcs_state_t          state;
    logic                 converter_enable;
    logic                 go;
    logic [3:0]           channel;
    logic [3:0]           port_config;
    logic                 vref_pos_ext;
    logic                 vref_neg_ext;
    logic                 result_align_select;
    logic [2:0]           auto_acquire_length;
    logic [2:0]           conv_clock_select;
    logic                 conv_complete_flag;
    logic                 conv_complete_irq_enable;
    logic [RESULT_W-1:0]  result;
    logic [RESULT_W-1:0]  trial;
    logic [RESULT_W-1:0]  next_trial;
    logic [RESULT_W-1:0]  next_trial_word;
    logic [5:0]           div_cnt;
    logic [5:0]           div_last;
    logic [4:0]           tad_cnt;
    logic [4:0]           acq_tads;
    logic [2:0]           holdoff_cnt;
    logic                 internal_rc_conv_clock;
    logic                 sys_tick;
    logic                 tad_tick;
    logic                 wr;
    logic                 complete;
    logic                 busy;
    logic [15:0]          res16;
    logic [31:0]          next_prdata;
    logic                 hit;

    assign wr = psel && penable && pready && pwrite;
    assign internal_rc_conv_clock = conv_clock_select[1:0] == CLK_RC_CODE;
    assign busy = state == st_holdoff || state == st_acq
               || state == st_conv;
    assign complete = state == st_conv && tad_tick
                   && tad_cnt == CONV_TADS - 5'h01;

    // conversion clock divider selection
    always_comb begin
        case (conv_clock_select)
            3'h0:    div_last = 6'h01;
            3'h1:    div_last = 6'h07;
            3'h2:    div_last = 6'h1f;
            3'h4:    div_last = 6'h03;
            3'h5:    div_last = 6'h0f;
            3'h6:    div_last = 6'h3f;
            default: div_last = 6'h01;
        endcase
    end

    always_comb begin
        case (auto_acquire_length)
            3'h0:    acq_tads = 5'h00;
            3'h1:    acq_tads = 5'h02;
            3'h2:    acq_tads = 5'h04;
            3'h3:    acq_tads = 5'h06;
            3'h4:    acq_tads = 5'h08;
            3'h5:    acq_tads = 5'h0c;
            3'h6:    acq_tads = 5'h10;
            default: acq_tads = 5'h14;
        endcase
    end

    // system clock stops in sleep, so only the RC source keeps ticking
    assign sys_tick = !device_sleep && div_cnt == div_last;
    assign tad_tick = internal_rc_conv_clock
                    ? rc_tick && state != st_holdoff
                    : sys_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 6'h00;
        end else if (state == st_idle || sys_tick) begin
            div_cnt <= 6'h00;
        end else if (!device_sleep) begin
            div_cnt <= div_cnt + 6'h01;
        end
    end

    // one successive approximation step, msb first
    always_comb begin
        next_trial = trial;
        for (int b = 0; b < RESULT_W; b++) begin
            if (int'(tad_cnt) == RESULT_W - 1 - b) begin
                next_trial[b] = cmp_above;
            end
            if (int'(tad_cnt) == RESULT_W - 2 - b) begin
                next_trial[b] = 1'b1;
            end
        end
    end

    always_comb begin
        next_trial_word = trial;
        if (state != st_conv) begin
            next_trial_word = TRIAL_START;
        end else if (tad_tick && int'(tad_cnt) < RESULT_W) begin
            next_trial_word = next_trial;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trial <= TRIAL_START;
        end else begin
            trial <= next_trial_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= st_idle;
            tad_cnt     <= 5'h00;
            holdoff_cnt <= 3'h0;
        end else if (!converter_enable) begin
            state       <= st_idle;
            tad_cnt     <= 5'h00;
            holdoff_cnt <= 3'h0;
        end else if (busy && !go) begin
            state   <= st_recover;
            tad_cnt <= 5'h00;
        end else begin
            case (state)
                st_idle: begin
                    tad_cnt     <= 5'h00;
                    holdoff_cnt <= 3'h0;
                    if (go) begin
                        if (internal_rc_conv_clock) begin
                            state <= st_holdoff;
                        end else if (auto_acquire_length == ACQ_NONE) begin
                            state <= st_conv;
                        end else begin
                            state <= st_acq;
                        end
                    end
                end
                st_holdoff: begin
                    holdoff_cnt <= holdoff_cnt + 3'h1;
                    if (holdoff_cnt == HOLDOFF_CYCLES - 3'h1) begin
                        state <= auto_acquire_length == ACQ_NONE
                               ? st_conv : st_acq;
                    end
                end
                st_acq: begin
                    if (tad_tick) begin
                        if (tad_cnt == acq_tads - 5'h01) begin
                            state   <= st_conv;
                            tad_cnt <= 5'h00;
                        end else begin
                            tad_cnt <= tad_cnt + 5'h01;
                        end
                    end
                end
                st_conv: begin
                    if (tad_tick) begin
                        if (complete) begin
                            state   <= st_recover;
                            tad_cnt <= 5'h00;
                        end else begin
                            tad_cnt <= tad_cnt + 5'h01;
                        end
                    end
                end
                st_recover: begin
                    if (tad_tick) begin
                        if (tad_cnt == RECOVER_TADS - 5'h01) begin
                            state <= st_idle;
                        end else begin
                            tad_cnt <= tad_cnt + 5'h01;
                        end
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_enable <= CTRL0_RESET[CTRL0_ENABLE];
            channel          <= CTRL0_RESET[CTRL0_CHAN_LSB +: 4];
        end else if (wr && paddr == ADDR_CTRL0) begin
            converter_enable <= pwdata[CTRL0_ENABLE];
            channel          <= pwdata[CTRL0_CHAN_LSB +: 4];
        end
    end

    // go stays set through acquisition and conversion alike
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go <= CTRL0_RESET[CTRL0_GO];
        end else if (wr && paddr == ADDR_CTRL0) begin
            go <= pwdata[CTRL0_GO] && pwdata[CTRL0_ENABLE];
        end else if (complete || !converter_enable) begin
            go <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_config  <= PINREF_RESET[PINREF_CFG_LSB +: 4];
            vref_pos_ext <= PINREF_RESET[PINREF_VPOS];
            vref_neg_ext <= PINREF_RESET[PINREF_VNEG];
        end else if (wr && paddr == ADDR_PINREF) begin
            port_config  <= pwdata[PINREF_CFG_LSB +: 4];
            vref_pos_ext <= pwdata[PINREF_VPOS];
            vref_neg_ext <= pwdata[PINREF_VNEG];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_align_select <= TIMING_RESET[TIMING_ALIGN];
            auto_acquire_length <= TIMING_RESET[TIMING_ACQ_LSB +: 3];
            conv_clock_select   <= TIMING_RESET[TIMING_CLK_LSB +: 3];
        end else if (wr && paddr == ADDR_TIMING) begin
            result_align_select <= pwdata[TIMING_ALIGN];
            auto_acquire_length <= pwdata[TIMING_ACQ_LSB +: 3];
            conv_clock_select   <= pwdata[TIMING_CLK_LSB +: 3];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_complete_flag       <= 1'b0;
            conv_complete_irq_enable <= 1'b0;
        end else begin
            if (complete) begin
                conv_complete_flag <= 1'b1;
            end else if (wr && paddr == ADDR_IRQ && pwdata[IRQ_FLAG]) begin
                conv_complete_flag <= 1'b0;
            end
            if (wr && paddr == ADDR_IRQ) begin
                conv_complete_irq_enable <= pwdata[IRQ_ENABLE];
            end
        end
    end

    // result pair keeps its contents through reset
    always_ff @(posedge pclk) begin
        if (complete) begin
            result <= trial;
        end
    end

    assign res16 = result_align_select
                 ? {6'h00, result} : {result, 6'h00};

    always_comb begin
        hit = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL0: begin
                next_prdata[CTRL0_ENABLE]       = converter_enable;
                next_prdata[CTRL0_GO]           = go;
                next_prdata[CTRL0_CHAN_LSB +: 4] = channel;
            end
            ADDR_PINREF: begin
                next_prdata[PINREF_CFG_LSB +: 4] = port_config;
                next_prdata[PINREF_VPOS]         = vref_pos_ext;
                next_prdata[PINREF_VNEG]         = vref_neg_ext;
            end
            ADDR_TIMING: begin
                next_prdata[TIMING_ALIGN]        = result_align_select;
                next_prdata[TIMING_ACQ_LSB +: 3] = auto_acquire_length;
                next_prdata[TIMING_CLK_LSB +: 3] = conv_clock_select;
            end
            ADDR_RESH:   next_prdata[7:0] = res16[15:8];
            ADDR_RESL:   next_prdata[7:0] = res16[7:0];
            ADDR_IRQ: begin
                next_prdata[IRQ_FLAG]   = conv_complete_flag;
                next_prdata[IRQ_ENABLE] = conv_complete_irq_enable;
            end
            default:     hit = 1'b0;
        endcase
    end

    // one wait-free access phase: answer prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog   <= '0;
            conv_irq <= 1'b0;
        end else begin
            analog.power        <= converter_enable;
            analog.sample       <= converter_enable
                && (state == st_idle || state == st_holdoff
                    || state == st_acq);
            analog.hold         <= state == st_conv;
            analog.vref_pos_ext <= vref_pos_ext;
            analog.vref_neg_ext <= vref_neg_ext;
            analog.channel      <= channel;
            analog.port_config  <= port_config;
            // leaves with next_trial_word rather than trial, so a registered comparator
            // answer is ready by the next tick at the fastest divider
            analog.trial        <= next_trial_word;
            conv_irq <= conv_complete_flag
                     && conv_complete_irq_enable;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_complete;
        complete |=> !go && conv_complete_flag && result == $past(trial);
    endproperty
    a_complete: assert property (p_complete)
        else $error("completion did not store result and flag");

    property p_abort;
        (state == st_conv && !go && converter_enable)
            |=> state == st_recover && $stable(result);
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort changed result or state");

    property p_zero_acq;
        (state == st_idle && go && converter_enable
         && !internal_rc_conv_clock && auto_acquire_length == ACQ_NONE)
            |=> state == st_conv;
    endproperty
    a_zero_acq: assert property (p_zero_acq)
        else $error("zero acquisition did not convert at once");

    property p_auto_acq;
        (state == st_idle && go && converter_enable
         && !internal_rc_conv_clock && auto_acquire_length != ACQ_NONE)
            |=> state == st_acq ##1 go;
    endproperty
    a_auto_acq: assert property (p_auto_acq)
        else $error("programmed acquisition not entered");

    property p_recover;
        (state != st_recover ##1 state == st_recover && converter_enable)
            |-> (state == st_recover) [*2];
    endproperty
    a_recover: assert property (p_recover)
        else $error("recovery wait too short");

    property p_holdoff;
        (state == st_idle && go && converter_enable
         && internal_rc_conv_clock)
            |=> state == st_holdoff;
    endproperty
    a_holdoff: assert property (p_holdoff)
        else $error("rc start skipped the holdoff");

    property p_hold;
        state == st_conv |=> analog.hold && !analog.sample;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold capacitor not isolated in conversion");

    property p_flag_sticky;
        (conv_complete_flag && !(wr && paddr == ADDR_IRQ
                                 && pwdata[IRQ_FLAG]))
            |=> conv_complete_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without a clear");

    property p_sleep;
        (device_sleep && !internal_rc_conv_clock) |-> !tad_tick;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("system clock ticked during sleep");

    property p_disable;
        !converter_enable |=> state == st_idle && !go;
    endproperty
    a_disable: assert property (p_disable)
        else $error("disabled converter still busy");

    property p_reserved;
        (psel && !penable && !pwrite && paddr == ADDR_TIMING)
            |=> !prdata[6] && pready;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("unused timing bit read nonzero");

    c_complete: cover property (complete);
    c_abort: cover property (state == st_conv && !go);
    c_acq: cover property (state == st_acq ##1 state == st_conv);
    c_rc: cover property (state == st_holdoff);
endmodule

//--- test/adc_sequencer_acq_timing_tb.sv
`timescale 1ns/1ps
module adc_sequencer_acq_timing_tb
    import adcs_pkg::*;
();
    logic         pclk         = 1'b0;
    logic         presetn      = 1'b0;
    logic         psel         = 1'b0;
    logic         penable      = 1'b0;
    logic         pwrite       = 1'b0;
    logic [7:0]   paddr        = 8'h00;
    logic [31:0]  pwdata       = 32'h0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         rc_tick      = 1'b0;
    logic         device_sleep = 1'b0;
    logic         cmp_above    = 1'b0;
    adcs_analog_t analog;
    logic         conv_irq;
    logic [9:0]   target       = 10'h0;
    logic [9:0]   m_res        = 10'h0;
    logic [15:0]  lfsr         = 16'h0029;
    int           n_fail       = 0;
    int           comparisons  = 0;
    int           cyc          = 0;
    int           rc_cnt       = 0;
    int           rc_per       = 5;
    int           chan         = 0;
    int           ck_tab[8]    = '{0, 4, 1, 5, 2, 6, 3, 7};
    int           acq_len[8]   = '{0, 2, 4, 6, 8, 12, 16, 20};
    logic [31:0]  tim;

    adcs_sequencer #(.RESULT_W(10)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rc_tick(rc_tick),
        .device_sleep(device_sleep), .cmp_above(cmp_above),
        .analog(analog), .conv_irq(conv_irq)
    );

    always #5 pclk = ~pclk;

    // comparator and free-running rc oscillator stand in for the analog side
    always @(posedge pclk) begin
        cmp_above <= ((analog.trial <= target) === 1'b1);
        rc_cnt    <= (rc_cnt + 1) % rc_per;
        rc_tick   <= (rc_cnt == 0);
        cyc       <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            close_out();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic int conv_clock_period(input int ck);
        case (ck)
            0: return 2;
            4: return 4;
            1: return 8;
            5: return 16;
            2: return 32;
            6: return 64;
            default: return rc_per;
        endcase
    endfunction

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g,
                           input int tol);
        comparisons++;
        if (g < e - tol || g > e + tol) begin
            n_fail++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        chk("pslverr", 32'(a > ADDR_IRQ), 32'(pslverr));
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask

    task automatic chk_res(input logic right);
        logic [15:0] v;
        v = right ? {6'h0, m_res} : {m_res, 6'h0};
        rd("result_high_byte", ADDR_RESH, {24'h0, v[15:8]});
        rd("result_low_byte", ADDR_RESL, {24'h0, v[7:0]});
    endtask

    task automatic run(input int ck, input int ac, input int extra,
                       input int slack);
        int n;
        int e;
        int m;
        int t;
        n = conv_clock_period(ck);
        e = n * (acq_len[ac] + 11 + extra) + 2 + ((ck % 4 == 3) ? 4 : 0);
        lfsr = lfsr_next(lfsr);
        target = lfsr[9:0];
        wr(ADDR_CTRL0, 32'((chan << 2) | 3));
        m = 0;
        while (conv_irq !== 1'b1 && m < 5000) begin
            @(posedge pclk);
            m++;
        end
        t = slack + ((ck % 4 == 3) ? rc_per : 0);
        chk_cnt("conv_cycles", e, m, t);
        m_res = target;
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctrl0", ADDR_CTRL0, 32'h0);
        rd("timing", ADDR_TIMING, 32'h0);
        rd("unmapped", 8'h18, 32'h0);
        wr(8'h1c, 32'hff);
        wr(ADDR_TIMING, 32'hff);
        rd("timing", ADDR_TIMING, 32'hbf);
        wr(ADDR_PINREF, 32'h3a);
        rd("pinref", ADDR_PINREF, 32'h3a);
        chk("vref", 32'h3,
            32'({analog.vref_neg_ext, analog.vref_pos_ext}));
        chk("port_config", 32'ha, 32'(analog.port_config));
        wr(ADDR_CTRL0, 32'h2);
        rd("ctrl0", ADDR_CTRL0, 32'h0);
        wr(ADDR_IRQ, 32'h2);
        wr(ADDR_CTRL0, 32'h1);
        repeat (2) @(posedge pclk);
        chk("power", 32'h1, 32'(analog.power));
        for (int i = 0; i < 8; i++) begin
            chan = i + 3;
            device_sleep <= (i == 7);
            tim = 32'((i % 2) << 7 | (i << 3) | ck_tab[i]);
            wr(ADDR_TIMING, tim);
            rd("timing", ADDR_TIMING, tim);
            run(ck_tab[i], i, 0, 3);
            chk("channel", 32'(chan), 32'(analog.channel));
            rd("ctrl0", ADDR_CTRL0, 32'((chan << 2) | 1));
            rd("irq", ADDR_IRQ, 32'h3);
            wr(ADDR_RESH, 32'hff);
            chk_res(i % 2);
            wr(ADDR_IRQ, 32'h3);
            repeat (2) @(posedge pclk);
            chk("conv_irq", 32'h0, 32'(conv_irq));
            repeat (2 * conv_clock_period(ck_tab[i]) + 2) @(posedge pclk);
            chk("sample", 32'h1, 32'(analog.sample));
        end
        // masked completion under sleep with the rc clock
        wr(ADDR_IRQ, 32'h0);
        lfsr = lfsr_next(lfsr);
        target = lfsr[9:0];
        wr(ADDR_CTRL0, 32'((chan << 2) | 3));
        repeat (200) @(posedge pclk);
        m_res = target;
        chk("conv_irq", 32'h0, 32'(conv_irq));
        rd("irq", ADDR_IRQ, 32'h1);
        chk_res(1'b1);
        wr(ADDR_IRQ, 32'h2);
        repeat (2) @(posedge pclk);
        chk("conv_irq", 32'h1, 32'(conv_irq));
        wr(ADDR_IRQ, 32'h3);
        repeat (2) @(posedge pclk);
        chk("conv_irq", 32'h0, 32'(conv_irq));
        device_sleep <= 1'b0;
        repeat (20) @(posedge pclk);
        // abort in mid conversion, then restart inside recovery
        wr(ADDR_TIMING, 32'hbe);
        lfsr = lfsr_next(lfsr);
        target = lfsr[9:0];
        wr(ADDR_CTRL0, 32'((chan << 2) | 3));
        repeat (100) @(posedge pclk);
        rd("ctrl0", ADDR_CTRL0, 32'((chan << 2) | 3));
        chk("sample", 32'h1, 32'(analog.sample));
        repeat (1300) @(posedge pclk);
        rd("ctrl0", ADDR_CTRL0, 32'((chan << 2) | 3));
        chk("hold", 32'h1, 32'(analog.hold));
        chk("sample", 32'h0, 32'(analog.sample));
        wr(ADDR_CTRL0, 32'((chan << 2) | 1));
        chk_res(1'b1);
        rd("irq", ADDR_IRQ, 32'h2);
        run(6, 7, 2, 16);
        rd("ctrl0", ADDR_CTRL0, 32'((chan << 2) | 1));
        chk_res(1'b1);
        // reset while go waits out recovery keeps the result pair
        wr(ADDR_CTRL0, 32'((chan << 2) | 3));
        repeat (50) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctrl0", ADDR_CTRL0, 32'h0);
        rd("pinref", ADDR_PINREF, 32'h0);
        rd("timing", ADDR_TIMING, 32'h0);
        rd("irq", ADDR_IRQ, 32'h0);
        chk("power", 32'h0, 32'(analog.power));
        chk_res(1'b0);
        close_out();
    end
endmodule
